/* verilog/agp_ctrl.sv */
// Gain control and protection supervisor for a mono class-D stage.
// Assumes async fault flags and audio clocks from pins, APB master on pclk.
// Notes on behaviour
// - Clip flag starts stepped gain reduction
// - Cut stops on clip clear or limit
// - Hold gain after last clip
// - After hold, raise gain at decay rate
// - Gain never cut below minimum gain
// - Attack step multiplies by 1-1/64
// - Short for 14us: drivers off 67ms
// - Retry after off time, repeat forever
// - Undervoltage turns drivers off only
// - Power-on reset forces driver down
// - Hot off; cool 100us re-enable
// - Clock loss shuts the driver down
// - Reset puts everything powered down
// - Enable and clocks start power-up
// - Power-up audible within 10 ms
// - Power-down about 22us after clocks stop
// - Level control only in its gain mode
// - Mute 2.7 ms on power-up grant
// - Unmute one step per 512 cycles
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
module agp_ctrl
  import agp_pkg::*;
#(
  parameter int unsigned OC_OFF_CYCLES = agp_pkg::OC_OFF_CYC,
  parameter int unsigned MUTE_CYCLES = agp_pkg::MUTE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_pin,
  input wire logic level_mode_pin,
  input wire logic bclk_pin,
  input wire logic fsync_pin,
  input wire logic clip_pin,
  input wire logic short_pin,
  input wire logic uv_pin,
  input wire logic hot_pin,
  input wire logic cool_pin,
  output logic drivers_on,
  output logic analog_mute,
  output logic power_up_grant,
  output logic [15:0] gain
);
  import agp_pkg::*;

  function automatic logic [15:0] step_down(input logic [15:0] g);
    step_down = g - (g >> GAIN_SHIFT);
  endfunction : step_down

  function automatic logic [15:0] step_up(input logic [15:0] g);
    step_up = g + (g >> GAIN_SHIFT) + 16'h0001;
  endfunction : step_up

  logic en_s, mode_s, bclk_s, fs_s, clip_s, short_s, uv_s, hot_s, cool_s;
  logic bclk_alive, fs_alive;

  agp_sync u_s_en (.pclk(pclk), .presetn(presetn), .d(enable_pin), .q(en_s));
  agp_sync u_s_md (.pclk(pclk), .presetn(presetn), .d(level_mode_pin), .q(mode_s));
  agp_sync u_s_bc (.pclk(pclk), .presetn(presetn), .d(bclk_pin), .q(bclk_s));
  agp_sync u_s_fs (.pclk(pclk), .presetn(presetn), .d(fsync_pin), .q(fs_s));
  agp_sync u_s_cl (.pclk(pclk), .presetn(presetn), .d(clip_pin), .q(clip_s));
  agp_sync u_s_sh (.pclk(pclk), .presetn(presetn), .d(short_pin), .q(short_s));
  agp_sync u_s_uv (.pclk(pclk), .presetn(presetn), .d(uv_pin), .q(uv_s));
  agp_sync u_s_ht (.pclk(pclk), .presetn(presetn), .d(hot_pin), .q(hot_s));
  agp_sync u_s_co (.pclk(pclk), .presetn(presetn), .d(cool_pin), .q(cool_s));
  agp_clkdet u_det_bc (.pclk(pclk), .presetn(presetn), .sig(bclk_s), .alive(bclk_alive));
  agp_clkdet u_det_fs (.pclk(pclk), .presetn(presetn), .sig(fs_s), .alive(fs_alive));

  // Registers
  logic ctrl_q;
  logic [23:0] attack_q, hold_q, decay_q;
  logic [15:0] min_gain_q;
  logic [7:0] max_cut_q;
  logic [31:0] prdata_q;

  wire apb_setup = psel && !penable;
  // Writes land at the access edge, where the master sees pready high
  wire apb_wr = psel && penable && pready && pwrite;
  wire apb_rd = apb_setup && !pwrite;
  wire hit = (paddr <= OFS_GAIN) && (paddr[1:0] == 2'b00);

  // Protection state
  logic [12:0] oc_cnt_q;
  logic [26:0] oc_off_q;
  logic oc_trip_q;
  logic hot_trip_q;
  logic [13:0] cool_cnt_q;
  wire oc_fault = oc_trip_q;
  wire fault = oc_fault || uv_s || hot_trip_q;
  wire clocks_ok = bclk_alive && fs_alive;
  wire grant_d = en_s && clocks_ok;

  // Power sequencer
  agp_pwr_t pwr_q;
  logic [18:0] seq_cnt_q;
  logic [7:0] unmute_q;

  // Level controller
  agp_lvl_t lvl_q;
  logic [15:0] lvl_gain_q;
  logic [23:0] lvl_cnt_q;
  logic [7:0] cut_cnt_q;
  wire level_on = mode_s && ctrl_q;
  wire lvl_tick_atk = lvl_cnt_q >= attack_q;
  wire lvl_tick_hold = lvl_cnt_q >= hold_q;
  wire lvl_tick_dcy = lvl_cnt_q >= decay_q;
  wire [15:0] lvl_down = step_down(lvl_gain_q);
  wire [15:0] lvl_up = step_up(lvl_gain_q);
  wire [15:0] lvl_down_clamped = (lvl_down < min_gain_q) ? min_gain_q : lvl_down;
  wire [15:0] lvl_up_clamped = (lvl_up > GAIN_UNITY || lvl_up < lvl_gain_q) ? GAIN_UNITY : lvl_up;
  wire [15:0] ramp_gain = {unmute_q, 8'h00};
  wire [15:0] out_gain = (ramp_gain < lvl_gain_q) ? ramp_gain : lvl_gain_q;

  // APB slave: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 1'b1;
      attack_q <= RST_ATTACK;
      hold_q <= RST_HOLD;
      decay_q <= RST_DECAY;
      min_gain_q <= RST_MINGAIN;
      max_cut_q <= RST_MAXCUT;
      prdata_q <= '0;
    end else if (apb_wr && hit) begin
      case (paddr)
        OFS_CTRL: ctrl_q <= pwdata[0];
        OFS_ATTACK: attack_q <= pwdata[23:0];
        OFS_HOLD: hold_q <= pwdata[23:0];
        OFS_DECAY: decay_q <= pwdata[23:0];
        OFS_MINGAIN: min_gain_q <= pwdata[15:0];
        OFS_MAXCUT: max_cut_q <= pwdata[7:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end else if (apb_rd) begin
      case (paddr)
        OFS_CTRL: prdata_q <= {31'h0, ctrl_q};
        OFS_ATTACK: prdata_q <= {8'h00, attack_q};
        OFS_HOLD: prdata_q <= {8'h00, hold_q};
        OFS_DECAY: prdata_q <= {8'h00, decay_q};
        OFS_MINGAIN: prdata_q <= {16'h0000, min_gain_q};
        OFS_MAXCUT: prdata_q <= {24'h000000, max_cut_q};
        OFS_STATUS: prdata_q <= {22'h0, lvl_q, pwr_q, hot_trip_q, uv_s, oc_trip_q, clocks_ok, en_s};
        OFS_GAIN: prdata_q <= {16'h0000, gain};
        default: prdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !hit;
    end
  end
  assign prdata = prdata_q;

  // Over-current: qualify, then timed off period, then retry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt_q <= '0;
      oc_off_q <= '0;
      oc_trip_q <= 1'b0;
    end else if (oc_trip_q) begin
      oc_cnt_q <= '0;
      if (oc_off_q >= 27'(OC_OFF_CYCLES - 1)) begin
        oc_trip_q <= 1'b0;
        oc_off_q <= '0;
      end else begin
        oc_off_q <= oc_off_q + 27'h1;
      end
    end else if (short_s && drivers_on) begin
      if (oc_cnt_q >= 13'(OC_DETECT_CYC - 1)) begin
        oc_trip_q <= 1'b1;
      end else begin
        oc_cnt_q <= oc_cnt_q + 13'h1;
      end
    end else begin
      oc_cnt_q <= '0;
    end
  end

  // Over-temperature with cool qualification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_trip_q <= 1'b0;
      cool_cnt_q <= '0;
    end else if (hot_s) begin
      hot_trip_q <= 1'b1;
      cool_cnt_q <= '0;
    end else if (hot_trip_q && cool_s) begin
      if (cool_cnt_q >= 14'(COOL_HOLD_CYC - 1)) begin
        hot_trip_q <= 1'b0;
        cool_cnt_q <= '0;
      end else begin
        cool_cnt_q <= cool_cnt_q + 14'h1;
      end
    end else begin
      cool_cnt_q <= '0;
    end
  end

  // Power-up sequence: mute, then soft unmute ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= AGP_OFF;
      seq_cnt_q <= '0;
      unmute_q <= '0;
    end else if (!grant_d) begin
      pwr_q <= AGP_OFF;
      seq_cnt_q <= '0;
      unmute_q <= '0;
    end else begin
      case (pwr_q)
        AGP_OFF: begin
          pwr_q <= AGP_MUTE;
          seq_cnt_q <= '0;
        end
        AGP_MUTE: begin
          if (seq_cnt_q >= 19'(MUTE_CYCLES - 1)) begin
            pwr_q <= AGP_UNMUTE;
            seq_cnt_q <= '0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 19'h1;
          end
        end
        AGP_UNMUTE: begin
          if (seq_cnt_q >= 19'(UNMUTE_STEP_CYC - 1)) begin
            seq_cnt_q <= '0;
            unmute_q <= unmute_q + 8'h01;
            if (unmute_q == UNMUTE_STEPS - 8'h01) begin
              pwr_q <= AGP_RUN;
            end
          end else begin
            seq_cnt_q <= seq_cnt_q + 19'h1;
          end
        end
        AGP_RUN: unmute_q <= UNMUTE_STEPS;
        default: pwr_q <= AGP_OFF;
      endcase
    end
  end

  // Automatic level control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= AGP_IDLE;
      lvl_gain_q <= GAIN_UNITY;
      lvl_cnt_q <= '0;
      cut_cnt_q <= '0;
    end else if (!level_on) begin
      lvl_q <= AGP_IDLE;
      lvl_gain_q <= GAIN_UNITY;
      lvl_cnt_q <= '0;
      cut_cnt_q <= '0;
    end else begin
      case (lvl_q)
        AGP_IDLE, AGP_DECAY: begin
          if (clip_s) begin
            lvl_q <= AGP_ATTACK;
            lvl_cnt_q <= attack_q;
            cut_cnt_q <= '0;
          end else if (lvl_q == AGP_DECAY) begin
            if (lvl_gain_q >= GAIN_UNITY) begin
              lvl_q <= AGP_IDLE;
            end else if (lvl_tick_dcy) begin
              lvl_gain_q <= lvl_up_clamped;
              lvl_cnt_q <= '0;
            end else begin
              lvl_cnt_q <= lvl_cnt_q + 24'h1;
            end
          end
        end
        AGP_ATTACK: begin
          if (!clip_s || cut_cnt_q >= max_cut_q) begin
            lvl_q <= AGP_HOLD;
            lvl_cnt_q <= '0;
          end else if (lvl_tick_atk) begin
            lvl_gain_q <= lvl_down_clamped;
            cut_cnt_q <= cut_cnt_q + 8'h01;
            lvl_cnt_q <= '0;
          end else begin
            lvl_cnt_q <= lvl_cnt_q + 24'h1;
          end
        end
        AGP_HOLD: begin
          if (clip_s) begin
            lvl_cnt_q <= '0;
          end else if (lvl_tick_hold) begin
            lvl_q <= AGP_DECAY;
            lvl_cnt_q <= '0;
          end else begin
            lvl_cnt_q <= lvl_cnt_q + 24'h1;
          end
        end
        default: lvl_q <= AGP_IDLE;
      endcase
    end
  end

  // Outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drivers_on <= 1'b0;
      analog_mute <= 1'b1;
      power_up_grant <= 1'b0;
      gain <= '0;
    end else begin
      drivers_on <= (pwr_q != AGP_OFF) && !fault;
      analog_mute <= (pwr_q == AGP_OFF) || (pwr_q == AGP_MUTE);
      power_up_grant <= grant_d;
      gain <= (pwr_q == AGP_RUN) ? lvl_gain_q : ((pwr_q == AGP_UNMUTE) ? out_gain : 16'h0000);
    end
  end
endmodule : agp_ctrl

/* verilog/agp_pkg.sv */
// Package for the amplifier gain and protection controller.
// Assumes a 100 MHz pclk and APB register access.
package agp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Timing figures in their own units, and derived cycle counts
  localparam int unsigned OC_DETECT_NS = 14000;
  localparam int unsigned OC_OFF_MS = 67;
  localparam int unsigned COOL_HOLD_NS = 100000;
  localparam int unsigned MUTE_US = 2700;
  localparam int unsigned CLK_LOSS_NS = 22000;
  localparam int unsigned OC_DETECT_CYC = (OC_DETECT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OC_OFF_CYC = OC_OFF_MS * 1000 * CLK_MHZ;
  localparam int unsigned COOL_HOLD_CYC = (COOL_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MUTE_CYC = MUTE_US * CLK_MHZ;
  localparam int unsigned CLK_LOSS_CYC = (CLK_LOSS_NS * CLK_MHZ) / 1000;
  localparam int unsigned UNMUTE_STEP_CYC = 512;
  // Gain word: 16-bit linear, 0x8000 is 0 dB
  localparam logic [15:0] GAIN_UNITY = 16'h8000;
  localparam int unsigned GAIN_SHIFT = 6;
  localparam logic [7:0] UNMUTE_STEPS = 8'hff;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ATTACK = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_DECAY = 8'h0c;
  localparam logic [7:0] OFS_MINGAIN = 8'h10;
  localparam logic [7:0] OFS_MAXCUT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_GAIN = 8'h1c;
  // Reset values
  localparam logic [23:0] RST_ATTACK = 24'h000064;
  localparam logic [23:0] RST_HOLD = 24'h0f4240;
  localparam logic [23:0] RST_DECAY = 24'h002710;
  localparam logic [15:0] RST_MINGAIN = 16'h2000;
  localparam logic [7:0] RST_MAXCUT = 8'h10;
  typedef enum logic [2:0] {AGP_OFF, AGP_MUTE, AGP_UNMUTE, AGP_RUN} agp_pwr_t;
  typedef enum logic [1:0] {AGP_IDLE, AGP_ATTACK, AGP_HOLD, AGP_DECAY} agp_lvl_t;
endpackage : agp_pkg

/* verilog/agp_sync.sv */
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/100ps
module agp_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic s1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule : agp_sync

/* verilog/agp_clkdet.sv */
// Activity detector for a sampled audio clock.
// Assumes the input is already synchronised to pclk.
`timescale 1ns/100ps
module agp_clkdet
  import agp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sig,
  output logic alive
);
  logic prev_q;
  logic [11:0] cnt_q;
  wire edge_seen = sig ^ prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      alive <= 1'b0;
    end else begin
      prev_q <= sig;
      if (edge_seen) begin
        cnt_q <= '0;
        alive <= 1'b1;
      end else if (cnt_q >= 12'(CLK_LOSS_CYC - 1)) begin
        alive <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end
endmodule : agp_clkdet

/* sim/agp_ctrl_props.sv */
// Port checker for the gain and protection controller.
// Assumes a bind onto agp_ctrl and one pclk domain.
`timescale 1ns/100ps
module agp_ctrl_props
  import agp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable_pin,
  input wire logic bclk_pin,
  input wire logic short_pin,
  input wire logic hot_pin,
  input wire logic drivers_on,
  input wire logic analog_mute,
  input wire logic power_up_grant,
  input wire logic [15:0] gain
);
  logic [11:0] idle_q;
  logic [11:0] short_q;
  logic bclk_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Quiet bit clock time, and short time while driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 12'h000;
      short_q <= 12'h000;
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= bclk_pin;
      idle_q <= (bclk_pin != bclk_q) ? 12'h000 : idle_q + {11'h000, ~&idle_q};
      short_q <= (short_pin && drivers_on) ? short_q + {11'h000, ~&short_q} : 12'h000;
    end
  end
  sequence s_grant;
    $rose(power_up_grant);
  endsequence
  sequence s_muted;
    analog_mute [*8];
  endsequence
  property p_wake;
    $rose(presetn) |-> !drivers_on && analog_mute && !power_up_grant && gain == 16'h0000;
  endproperty
  a_wake: assert property (p_wake) else $error("not powered down after reset");
  property p_first;
    s_grant |-> s_muted;
  endproperty
  a_first: assert property (p_first) else $error("no mute after grant");
  property p_hot;
    hot_pin [*5] |-> !drivers_on;
  endproperty
  a_hot: assert property (p_hot) else $error("drivers on while hot");
  property p_idle;
    idle_q > 12'd2300 |-> !drivers_on && !power_up_grant;
  endproperty
  a_idle: assert property (p_idle) else $error("drivers on without clocks");
  property p_no_en;
    !enable_pin [*5] |-> !power_up_grant;
  endproperty
  a_no_en: assert property (p_no_en) else $error("grant without enable");
  property p_short;
    drivers_on |-> short_q < 12'd1410;
  endproperty
  a_short: assert property (p_short) else $error("short not cut off");
  property p_step;
    drivers_on && $past(drivers_on) && gain < $past(gain) |-> gain == $past(gain) - ($past(gain) >> 6);
  endproperty
  a_step: assert property (p_step) else $error("wrong attack step");
  property p_cap;
    gain <= GAIN_UNITY;
  endproperty
  a_cap: assert property (p_cap) else $error("gain above target");
endmodule : agp_ctrl_props
bind agp_ctrl agp_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .enable_pin(enable_pin), .bclk_pin(bclk_pin), .short_pin(short_pin),
  .hot_pin(hot_pin), .drivers_on(drivers_on), .analog_mute(analog_mute), .power_up_grant(power_up_grant),
  .gain(gain)
);

/* sim/agp_far_model.sv */
// Far side model: audio clock source and output short detector.
// Assumes run and short commands from the bench.
`timescale 1ns/100ps
module agp_far_model (
  input wire logic clk_run,
  input wire logic short_on,
  input wire logic drivers_on,
  output logic bclk_pin,
  output logic fsync_pin,
  output logic short_pin
);
  logic [3:0] div_q;
  initial begin
    bclk_pin = 1'b0;
    div_q = 4'h0;
    #3;
    forever begin
      #320;
      if (clk_run) begin // Clocks move only while commanded
        bclk_pin = ~bclk_pin;
        div_q = div_q + 4'h1;
      end
    end
  end
  assign fsync_pin = div_q[3];
  // Short seen only while the stage drives
  assign short_pin = short_on && drivers_on;
endmodule : agp_far_model

/* sim/amp_gain_and_protection_ctrl_bench.sv */
// Self-checking bench for the gain and protection controller.
// Assumes shortened off and mute counts and the far side model.
`timescale 1ns/100ps
module amp_gain_and_protection_ctrl_bench;
  import agp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, watch, clk_run, short_on;
  logic enable_pin, level_mode_pin, bclk_pin, fsync_pin, clip_pin, short_pin, uv_pin, hot_pin, cool_pin;
  logic drivers_on, analog_mute, power_up_grant;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, atk;
  logic [15:0] gain, g_last;
  logic [33:0] q;
  logic [33:0] apb_q[$];
  logic [15:0] gain_q[$];
  logic [31:0] rv[6];
  int fails, cmp_count, n;
  agp_ctrl #(.OC_OFF_CYCLES(200), .MUTE_CYCLES(100)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .level_mode_pin(level_mode_pin), .bclk_pin(bclk_pin), .fsync_pin(fsync_pin), .clip_pin(clip_pin),
    .short_pin(short_pin), .uv_pin(uv_pin), .hot_pin(hot_pin), .cool_pin(cool_pin),
    .drivers_on(drivers_on), .analog_mute(analog_mute), .power_up_grant(power_up_grant), .gain(gain)
  );
  agp_far_model i_far (.clk_run(clk_run), .short_on(short_on), .drivers_on(drivers_on),
    .bclk_pin(bclk_pin), .fsync_pin(fsync_pin), .short_pin(short_pin));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("Compared %0d, mismatched %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    apb_q.push_back({w, e, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
    @(posedge pclk);
  endtask : apb
  function automatic logic [15:0] probe(input int k);
    case (k)
      0: return {15'h0, drivers_on};
      1: return {15'h0, power_up_grant};
      2: return {15'h0, analog_mute};
      default: return gain;
    endcase
  endfunction : probe
  // Wait until an output equals v (or leaves it), then check the cycles taken
  task automatic wt(input int k, input logic [15:0] v, input int lo, input int hi, input logic ne = 1'b0);
    n = 0;
    while ((probe(k) === v) == ne && n <= hi) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
    if (n > hi)
      end_of_test();
  endtask : wt
  task automatic burst(input int len);
    watch <= 1'b1;
    clip_pin <= 1'b1;
    repeat (len) @(posedge pclk);
    clip_pin <= 1'b0;
    repeat (150) @(posedge pclk);
    watch <= 1'b0;
    chk(32'(gain_q.size()), 32'h0);
  endtask : burst
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      q = apb_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, q[32]});
      if (!q[33])
        chk(prdata, q[31:0]);
    end
    if (watch && gain !== g_last)
      chk({16'h0, gain}, {16'h0, gain_q.pop_front()});
    g_last = gain;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, enable_pin, clip_pin, uv_pin, hot_pin} = '0;
    {level_mode_pin, cool_pin, watch, clk_run, short_on} = 5'b11000;
    {fails, cmp_count} = '0;
    rv = '{32'h1, {8'h0, RST_ATTACK}, {8'h0, RST_HOLD}, {8'h0, RST_DECAY}, {16'h0, RST_MINGAIN}, {24'h0, RST_MAXCUT}};
    void'($urandom(32'hf489));
    repeat (6) @(posedge pclk);
    chk({13'h0, drivers_on, analog_mute, power_up_grant, gain}, {13'h0, 3'b010, 16'h0});
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++)
      apb(1'b0, 8'(4 * i), rv[i], 1'b0);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    atk = 32'h8 + ($urandom % 8);
    apb(1'b1, OFS_ATTACK, atk, 1'b0);
    apb(1'b0, OFS_ATTACK, atk, 1'b0);
    apb(1'b1, OFS_HOLD, 32'd200, 1'b0);
    apb(1'b1, OFS_DECAY, 32'd20, 1'b0);
    apb(1'b1, OFS_MAXCUT, 32'h3, 1'b0);
    enable_pin <= 1'b1;
    clk_run <= 1'b1;
    wt(1, 16'h1, 0, 2000);
    wt(2, 16'h0, 100, 110);
    wt(3, gain, 0, 600, 1'b1);
    wt(3, gain, 511, 513, 1'b1);
    wt(3, GAIN_UNITY, 0, 70000);
    gain_q = '{16'h7e00, 16'h7c08, 16'h7a18};
    burst(80);
    wt(3, GAIN_UNITY, 40, 600);
    apb(1'b1, OFS_MINGAIN, 32'h7c08, 1'b0);
    apb(1'b1, OFS_MAXCUT, 32'h8, 1'b0);
    gain_q = '{16'h7e00, 16'h7c08};
    burst(100);
    wt(3, GAIN_UNITY, 0, 600);
    level_mode_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    burst(80);
    level_mode_pin <= 1'b1;
    short_on <= 1'b1;
    wt(0, 16'h0, 1400, 1410);
    wt(0, 16'h1, 199, 206);
    wt(0, 16'h0, 1400, 1410);
    short_on <= 1'b0;
    wt(0, 16'h1, 199, 206);
    uv_pin <= 1'b1;
    wt(0, 16'h0, 1, 6);
    chk({31'h0, power_up_grant}, 32'h1);
    uv_pin <= 1'b0;
    wt(0, 16'h1, 1, 10);
    {hot_pin, cool_pin} <= 2'b10;
    wt(0, 16'h0, 1, 6);
    hot_pin <= 1'b0;
    repeat (50) @(posedge pclk);
    cool_pin <= 1'b1;
    wt(0, 16'h1, 10000, 10008);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({13'h0, drivers_on, analog_mute, power_up_grant, gain}, {13'h0, 3'b010, 16'h0});
    presetn <= 1'b1;
    wt(1, 16'h1, 0, 2000);
    wt(0, 16'h1, 0, 400);
    // No audio samples are modelled, so the stream is silent at clock stop
    clk_run <= 1'b0;
    wt(0, 16'h0, 1000, 2300);
    wt(1, 16'h0, 0, 10);
    end_of_test();
  end
endmodule : amp_gain_and_protection_ctrl_bench
